/* File: rtl/disp_entry_pkg.sv */
/*
  shared constants and types of the ascii display entry controller:
  control word fields, entry mode codes, command codes, reset values and timing.
  assumes a single 20 MHz core clock.
*/
package disp_entry_pkg;

  localparam int CLK_MHZ        = 20;
  localparam int READY_LOW_US   = 25;
  localparam int READY_LOW_CYC  = READY_LOW_US * CLK_MHZ;
  localparam int MRST_MS        = 50;
  localparam int MRST_CYC       = MRST_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC     = 4;
  localparam int DV_HALF_NS     = 1000;
  localparam int DV_HALF_CYC    = (DV_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W          = $clog2(READY_LOW_CYC);

  localparam int MEM_DEPTH      = 48;
  localparam int RAM_MAX_LEN    = 32;
  localparam int DUMP_WORDS     = 34;
  localparam int OUT_FIFO_DEPTH = 8;

  // control word field positions
  localparam int WORD_TYPE_BIT  = 7;
  localparam int MODE_HI        = 6;
  localparam int MODE_LO        = 5;
  localparam int LEN_HI         = 3;

  typedef enum logic [1:0] {
    MODE_RAM   = 2'h0,
    MODE_LEFT  = 2'h1,
    MODE_RIGHT = 2'h2,
    MODE_BLOCK = 2'h3
  } entry_mode_t;

  localparam logic [3:0] LEN_CODE_MAX     = 4'hb;
  localparam logic [3:0] LEN_CODE_MAX_RAM = 4'h7;
  localparam logic [3:0] RESET_LEN_CODE   = 4'h7;
  localparam logic [5:0] RESET_LEN        = 6'h20;
  localparam logic [5:0] RESET_CADDR      = 6'h10;
  localparam logic [5:0] CURSOR_OFFSCREEN = 6'h30;

  localparam logic [6:0] CH_SPACE         = 7'h20;
  localparam logic [6:0] FONT_LO          = 7'h20;
  localparam logic [6:0] FONT_HI          = 7'h5f;
  localparam logic [6:0] CMD_CLEAR        = 7'h0c;
  localparam logic [6:0] CMD_BACKSPACE    = 7'h08;
  localparam logic [6:0] CMD_CURSOR_RIGHT = 7'h09;
  localparam logic [6:0] CMD_INSERT       = 7'h0e;
  localparam logic [6:0] CMD_DELETE       = 7'h7f;

  // synchroniser idle: {master reset n, reduced font, chip select n, addr, data}
  localparam logic [15:0] PIN_IDLE        = 16'ha000;

endpackage : disp_entry_pkg

/* File: rtl/pin_sync.sv */
/*
  two flip-flop synchroniser for a bundle of pins.
  assumes each bit is a slow level; bundle skew is absorbed by the caller's settle delay.
*/
module pin_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   IDLE = '0
)(
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb
  begin
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      s_q <= '{s1: IDLE, s2: IDLE};
    else
      s_q <= s_d;
  end

  assign sync_o = s_q.s2;

endmodule : pin_sync

/* File: rtl/entry_fifo.sv */
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes one clock, synchronous active low reset.
*/
module entry_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        push;
  logic        pop;

  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rd];

  always_comb
  begin
    s_d  = s_q;
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr          = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop)
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    if (push && !pop)
      s_d.cnt = s_q.cnt + 1'b1;
    else if (pop && !push)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      s_q <= '{mem: '0, wr: '0, rd: '0, cnt: '0};
    else
      s_q <= s_d;
  end

endmodule : entry_fifo

/* File: rtl/ascii_display_entry_controller.sv */
/*
  entry logic of an alphanumeric display controller: host word port, four entry modes,
  character memory, cursor, refresh-gap data dump and master reset.
  assumes a 20 MHz core clock, host pins asynchronous, refresh gap pulse on the core clock.
*/
module ascii_display_entry_controller
  import disp_entry_pkg::*;
#(
  parameter int MRST_CYCLES = MRST_CYC,
  parameter int FIFO_DEPTH  = OUT_FIFO_DEPTH
)(
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       CHIP_SELECT_N_I,
  input  wire logic [7:0] DATA_IN_I,
  input  wire logic [4:0] ADDR_IN_I,
  input  wire logic       MASTER_RESET_N_I,
  input  wire logic       REDUCED_FONT_I,
  input  wire logic       REFRESH_GAP_I,
  input  wire logic [5:0] DISP_POS_I,
  output logic            READY_O,
  output logic      [7:0] DATA_OUT_O,
  output logic            DATA_VALID_N_O,
  output logic      [6:0] DISP_CHAR_O,
  output logic      [1:0] ENTRY_MODE_O,
  output logic      [5:0] DISPLAY_LEN_O,
  output logic      [5:0] CURSOR_ADDR_O,
  output logic            CURSOR_SHOWN_O,
  output logic            INSERT_ACTIVE_O
);

  localparam int MRW = $clog2(MRST_CYCLES + 1);

  typedef enum logic [2:0] {S_INIT, S_IDLE, S_SETTLE, S_EXEC, S_READY_LOW} ctl_state_t;

  typedef struct packed {
    ctl_state_t                  st;
    logic [MEM_DEPTH-1:0][6:0]   mem;
    entry_mode_t                 mode;
    logic [3:0]                  lc;
    logic [5:0]                  len;
    logic [5:0]                  cur;
    logic                        ins;
    logic                        cs_prev;
    logic [7:0]                  w;
    logic [4:0]                  a;
    logic [TMR_W-1:0]            tmr;
    logic [MRW-1:0]              mrst_cnt;
    logic                        mrst_done;
    logic [5:0]                  caddr;
    logic [6:0]                  disp;
    logic                        dumping;
    logic [5:0]                  didx;
    logic [5:0]                  dlast;
    logic                        pbusy;
    logic [7:0]                  pcnt;
    logic                        dv_n;
    logic [7:0]                  dout;
    logic [15:0]                 rlc;
  } core_state_t;

  localparam core_state_t RST = '{st: S_INIT, mem: {MEM_DEPTH{CH_SPACE}}, mode: MODE_LEFT,
    lc: RESET_LEN_CODE, len: RESET_LEN, cur: '0, ins: 1'b0, cs_prev: 1'b1, w: '0, a: '0,
    tmr: TMR_W'(SETTLE_CYC - 1), mrst_cnt: '0, mrst_done: 1'b0, caddr: RESET_CADDR, disp: CH_SPACE,
    dumping: 1'b0, didx: '0, dlast: '0, pbusy: 1'b0, pcnt: '0, dv_n: 1'b1, dout: '0, rlc: '0};

  core_state_t s_q;
  core_state_t s_d;
  logic [15:0] pins;
  logic        mrn;
  logic        rfont;
  logic        cs_n;
  logic [4:0]  ain;
  logic [7:0]  din;
  logic [6:0]  c;
  logic        font_ok;
  logic        is_cmd;
  logic        full;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [7:0]  f_out_data;
  logic [7:0]  dump_word;
  logic [6:0]  idx;

  // host pins are asynchronous; everything reads the second stage only
  pin_sync #(.W(16), .IDLE(PIN_IDLE)) u_sync (
    .core_clk_i (CORE_CLK_I),
    .resetn_i   (RESETN_I),
    .pin_i      ({MASTER_RESET_N_I, REDUCED_FONT_I, CHIP_SELECT_N_I, ADDR_IN_I, DATA_IN_I}),
    .sync_o     (pins)
  );
  assign {mrn, rfont, cs_n, ain, din} = pins;

  // dump words queue here so the slow data-valid pacing never stalls entry handling
  entry_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (CORE_CLK_I),
    .resetn_i    (RESETN_I),
    .in_valid_i  (s_q.dumping),
    .in_ready_o  (f_in_ready),
    .in_data_i   (dump_word),
    .out_valid_o (f_out_valid),
    .out_ready_i (!s_q.pbusy),
    .out_data_o  (f_out_data)
  );

  function automatic logic ctrl_ok(input logic [7:0] w);
    ctrl_ok = (w[LEN_HI:0] <= LEN_CODE_MAX) &&
              ((entry_mode_t'(w[MODE_HI:MODE_LO]) != MODE_RAM) || (w[LEN_HI:0] <= LEN_CODE_MAX_RAM));
  endfunction : ctrl_ok

  function automatic logic [5:0] len_of(input logic [3:0] lc);
    len_of = {lc + 4'h1, 2'b00};
  endfunction : len_of

  function automatic logic [6:0] map_idx(input entry_mode_t m, input logic [5:0] l, input logic [5:0] p);
    map_idx = (m == MODE_RIGHT) ? {1'b0, p} + 7'(MEM_DEPTH) - {1'b0, l} : {1'b0, p};
  endfunction : map_idx

  assign c       = s_q.w[6:0];
  assign font_ok = !rfont || (c >= FONT_LO && c <= FONT_HI);
  assign is_cmd  = (c == CMD_CLEAR) || (c == CMD_BACKSPACE) || (c == CMD_CURSOR_RIGHT) ||
                   (c == CMD_INSERT) || (c == CMD_DELETE);
  assign full    = (s_q.cur == s_q.len);

  always_comb
  begin
    s_d       = s_q;
    s_d.cs_prev = cs_n;
    s_d.rlc     = (s_q.st == S_IDLE) ? '0 : s_q.rlc + 1'b1;
    idx       = '0;
    dump_word = '0;
    case (s_q.st)
      S_INIT:
        // synchronisers leave reset holding idle, so the strap is only visible a few cycles later
        if (s_q.tmr != '0)
          s_d.tmr = s_q.tmr - 1'b1;
        else
        begin
          s_d.mem = {MEM_DEPTH{CH_SPACE}};
          s_d.cur = '0;
          s_d.ins = 1'b0;
          if (din[WORD_TYPE_BIT] && ctrl_ok(din))
          begin
            s_d.mode = entry_mode_t'(din[MODE_HI:MODE_LO]);
            s_d.lc   = din[LEN_HI:0];
          end
          else
          begin
            s_d.mode = MODE_LEFT;
            s_d.lc   = RESET_LEN_CODE;
          end
          s_d.len = len_of(s_d.lc);
          s_d.st  = S_IDLE;
        end
      S_IDLE:
        if (s_q.cs_prev && !cs_n)
        begin
          s_d.st  = S_SETTLE;
          s_d.tmr = TMR_W'(SETTLE_CYC - 1);
        end
      S_SETTLE:
        if (s_q.tmr == '0)
        begin
          // host still holds data and address here, long after the pin skew settles
          s_d.w  = din;
          s_d.a  = ain;
          s_d.st = S_EXEC;
        end
        else
          s_d.tmr = s_q.tmr - 1'b1;
      S_EXEC:
      begin
        s_d.st  = S_READY_LOW;
        s_d.tmr = TMR_W'(READY_LOW_CYC - 1);
        if (s_q.w[WORD_TYPE_BIT])
        begin
          if (ctrl_ok(s_q.w))
          begin
            s_d.mode = entry_mode_t'(s_q.w[MODE_HI:MODE_LO]);
            s_d.lc   = s_q.w[LEN_HI:0];
            s_d.len  = len_of(s_q.w[LEN_HI:0]);
            s_d.ins  = 1'b0;
            // addressed entry keeps memory; leaving it for left entry keeps the preloaded cursor
            if (!(s_d.mode == MODE_RAM || (s_q.mode == MODE_RAM && s_d.mode == MODE_LEFT)))
            begin
              s_d.mem = {MEM_DEPTH{CH_SPACE}};
              s_d.cur = '0;
            end
            else if (s_q.cur > s_d.len)
              s_d.cur = s_d.len;
          end
        end
        else
          case (s_q.mode)
            MODE_LEFT:
              if (c == CMD_CLEAR)
              begin
                s_d.mem = {MEM_DEPTH{CH_SPACE}};
                s_d.cur = '0;
                s_d.ins = 1'b0;
              end
              else if (c == CMD_BACKSPACE)
              begin
                if (s_q.cur != '0)
                  s_d.cur = s_q.cur - 1'b1;
                s_d.ins = 1'b0;
              end
              else if (full)
                s_d.cur = s_q.cur;
              else if (c == CMD_CURSOR_RIGHT)
              begin
                s_d.cur = s_q.cur + 1'b1;
                s_d.ins = 1'b0;
              end
              else if (c == CMD_DELETE)
              begin
                for (int i = 0; i < MEM_DEPTH - 1; i++)
                  if (6'(i) >= s_q.cur && 6'(i) < s_q.len - 1'b1)
                    s_d.mem[i] = s_q.mem[i+1];
                s_d.mem[s_q.len - 1'b1] = CH_SPACE;
                s_d.ins = 1'b0;
              end
              else if (c == CMD_INSERT)
                s_d.ins = !s_q.ins;
              else if (font_ok)
              begin
                if (s_q.ins)
                  for (int i = 1; i < MEM_DEPTH; i++)
                    if (6'(i) > s_q.cur && 6'(i) < s_q.len)
                      s_d.mem[i] = s_q.mem[i-1];
                s_d.mem[s_q.cur] = c;
                s_d.cur = s_q.cur + 1'b1;
              end
            MODE_RIGHT:
              if (c == CMD_CLEAR)
                s_d.mem = {MEM_DEPTH{CH_SPACE}};
              else if (c == CMD_BACKSPACE)
              begin
                for (int i = 1; i < MEM_DEPTH; i++)
                  s_d.mem[i] = s_q.mem[i-1];
                s_d.mem[0] = CH_SPACE;
              end
              else if (font_ok)
              begin
                for (int i = 0; i < MEM_DEPTH - 1; i++)
                  s_d.mem[i] = s_q.mem[i+1];
                s_d.mem[MEM_DEPTH-1] = c;
              end
            MODE_BLOCK:
              if (font_ok)
              begin
                s_d.mem[s_q.cur] = c;
                s_d.cur = (s_q.cur + 1'b1 >= s_q.len) ? '0 : s_q.cur + 1'b1;
              end
            MODE_RAM:
              if (font_ok && {1'b0, s_q.a} < s_q.len)
              begin
                s_d.mem[s_q.a] = c;
                s_d.cur = {1'b0, s_q.a} + 1'b1;
              end
            default:
              s_d.mode = MODE_LEFT;
          endcase
      end
      S_READY_LOW:
        if (s_q.tmr == '0)
          s_d.st = S_IDLE;
        else
          s_d.tmr = s_q.tmr - 1'b1;
      default:
        s_d.st = S_INIT;
    endcase
    if (s_d.mode == MODE_RIGHT)
      s_d.cur = s_d.len;
    // master reset: a glitch shorter than the hold time restarts the count
    if (mrn)
    begin
      s_d.mrst_cnt  = '0;
      s_d.mrst_done = 1'b0;
    end
    else if (!s_q.mrst_done)
    begin
      if (s_q.mrst_cnt == MRW'(MRST_CYCLES - 1))
      begin
        s_d.mrst_done = 1'b1;
        s_d.st        = S_INIT;
        s_d.tmr       = '0;
      end
      else
        s_d.mrst_cnt = s_q.mrst_cnt + 1'b1;
    end
    s_d.caddr = (s_d.mode == MODE_RIGHT) ? CURSOR_OFFSCREEN : CURSOR_OFFSCREEN - s_d.len + s_d.cur;
    idx       = map_idx(s_q.mode, s_q.len, DISP_POS_I);
    s_d.disp  = (idx < 7'(MEM_DEPTH)) ? s_q.mem[idx[5:0]] : CH_SPACE;
    // refresh-gap dump
    if (s_q.didx == '0)
      dump_word = {1'b1, s_q.mode, s_q.ins, s_q.lc};
    else if (s_q.didx == 6'h1)
      dump_word = {2'b00, s_q.caddr};
    else
    begin
      idx       = map_idx(s_q.mode, s_q.len, s_q.didx - 6'h2);
      dump_word = (idx < 7'(MEM_DEPTH)) ? {1'b0, s_q.mem[idx[5:0]]} : {1'b0, CH_SPACE};
    end
    if (!s_q.dumping && REFRESH_GAP_I)
    begin
      s_d.dumping = 1'b1;
      s_d.didx    = '0;
      s_d.dlast   = (s_q.len <= 6'(RAM_MAX_LEN)) ? 6'(DUMP_WORDS - 1) : '0;
    end
    else if (s_q.dumping && f_in_ready)
    begin
      if (s_q.didx == s_q.dlast)
        s_d.dumping = 1'b0;
      else
        s_d.didx = s_q.didx + 1'b1;
    end
    // data-valid pacing: data changes first, falling edge comes half a period later
    if (!s_q.pbusy && f_out_valid)
    begin
      s_d.pbusy = 1'b1;
      s_d.dout  = f_out_data;
      s_d.pcnt  = 8'(2 * DV_HALF_CYC - 1);
    end
    else if (s_q.pbusy)
    begin
      if (s_q.pcnt == 8'(DV_HALF_CYC))
        s_d.dv_n = 1'b0;
      if (s_q.pcnt == '0)
      begin
        s_d.dv_n  = 1'b1;
        s_d.pbusy = 1'b0;
      end
      else
        s_d.pcnt = s_q.pcnt - 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RESETN_I)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  assign READY_O         = (s_q.st == S_IDLE);
  assign DATA_OUT_O      = s_q.dout;
  assign DATA_VALID_N_O  = s_q.dv_n;
  assign DISP_CHAR_O     = s_q.disp;
  assign ENTRY_MODE_O    = s_q.mode;
  assign DISPLAY_LEN_O   = s_q.len;
  assign CURSOR_ADDR_O   = s_q.caddr;
  assign CURSOR_SHOWN_O  = (s_q.mode == MODE_LEFT);
  assign INSERT_ACTIVE_O = s_q.ins;

  logic exec_left;

  assign exec_left = (s_q.st == S_EXEC) && !s_q.w[WORD_TYPE_BIT] && (s_q.mode == MODE_LEFT) && mrn;

  a_ready_width: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(READY_O) && $past(s_q.st) == S_READY_LOW |-> s_q.rlc == 16'(READY_LOW_CYC + SETTLE_CYC + 1))
    else $error("ready low time wrong");
  a_mode_load: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_q.st == S_EXEC && s_q.w[WORD_TYPE_BIT] && ctrl_ok(s_q.w) && mrn
    |=> s_q.mode == entry_mode_t'($past(s_q.w[MODE_HI:MODE_LO])) && s_q.len == len_of($past(s_q.w[LEN_HI:0])))
    else $error("control word not loaded");
  a_ctrl_reject: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_q.st == S_EXEC && s_q.w[WORD_TYPE_BIT] && !ctrl_ok(s_q.w) && mrn |=> $stable(s_q.mode) && $stable(s_q.len))
    else $error("invalid control word accepted");
  a_left_advance: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    exec_left && !full && !s_q.ins && !is_cmd && font_ok
    |=> s_q.cur == $past(s_q.cur) + 6'h1 && s_q.mem[$past(s_q.cur)] == $past(c))
    else $error("left entry write or advance wrong");
  a_left_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    exec_left && c == CMD_CLEAR |=> s_q.cur == '0 && s_q.mem == {MEM_DEPTH{CH_SPACE}} && !s_q.ins)
    else $error("clear incomplete");
  a_backspace_move: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    exec_left && c == CMD_BACKSPACE && s_q.cur != '0
    |=> s_q.cur == $past(s_q.cur) - 6'h1 && $stable(s_q.mem) && !s_q.ins)
    else $error("backspace wrong");
  a_full_ignore: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    exec_left && full && c != CMD_BACKSPACE && c != CMD_CLEAR |=> $stable(s_q.mem) && $stable(s_q.cur))
    else $error("full display took input");
  a_insert_toggle: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    exec_left && !full && c == CMD_INSERT |=> s_q.ins != $past(s_q.ins))
    else $error("insert flag not toggled");
  a_right_cursor: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_q.mode == MODE_RIGHT |-> CURSOR_ADDR_O == CURSOR_OFFSCREEN)
    else $error("right entry cursor not off-screen");
  a_ram_range: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_q.st == S_EXEC && !s_q.w[WORD_TYPE_BIT] && s_q.mode == MODE_RAM && {1'b0, s_q.a} >= s_q.len && mrn
    |=> $stable(s_q.mem) && $stable(s_q.cur))
    else $error("out of range address written");

endmodule : ascii_display_entry_controller

/* File: test/host_model.sv */
/*
  host model of the word port: drives chip select, data and address words.
  assumes the device ready output and the shared core clock.
*/
module host_model
  import disp_entry_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  output logic            cs_n_o,
  output logic      [7:0] data_o,
  output logic      [4:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // longest hold of any mode, so one figure keeps every mode safe
  localparam int HOLD_CYC = 135 * CLK_MHZ;
  int            low_cyc;
  initial
  begin
    cs_n_o = 1'b1;
    data_o = 8'h00;
    addr_o = 5'h00;
  end
  // word presented while idle, seen by a master reset
  task automatic strap(input logic [7:0] w);
    data_o = w;
  endtask : strap
  task automatic send(input logic [7:0] w, input logic [4:0] a);
    int n;
    for (n = 0; n < 2000 && ready_i !== 1'b1; n++)
    begin
      @(negedge clk_i);
    end
    cs_n_o  = 1'b0;
    data_o  = w;
    addr_o  = a;
    low_cyc = 0;
    for (n = 0; n < HOLD_CYC; n++)
    begin
      @(negedge clk_i);
      if (ready_i === 1'b0)
        low_cyc++;
    end
    // released lines show no stale value
    cs_n_o = 1'b1;
    data_o = ~w;
    addr_o = ~a;
    @(negedge clk_i);
  endtask : send
endmodule : host_model

/* File: test/ascii_display_entry_controller_tb.sv */
/*
  self-checking bench of the display entry controller driven by the host model.
  assumes a 20 MHz core clock and a shortened master reset count.
*/
module ascii_display_entry_controller_tb;
  import disp_entry_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rstn, cs_n, mrst_n, gap, ready, dv_n, shown, ins, rfont;
  logic [7:0] din, dout;
  logic [4:0] addr;
  logic [5:0] pos, len, caddr;
  logic [6:0] ch;
  logic [1:0] mode;
  logic [6:0] c [4];
  logic [3:0] code;
  int         num_errors, tests_run, seed, i;
  host_model u_host (.clk_i(clk), .ready_i(ready), .cs_n_o(cs_n), .data_o(din), .addr_o(addr));
  ascii_display_entry_controller #(.MRST_CYCLES(16), .FIFO_DEPTH(8)) u_dut (
    .CORE_CLK_I(clk), .RESETN_I(rstn), .CHIP_SELECT_N_I(cs_n), .DATA_IN_I(din), .ADDR_IN_I(addr),
    .MASTER_RESET_N_I(mrst_n), .REDUCED_FONT_I(rfont), .REFRESH_GAP_I(gap), .DISP_POS_I(pos),
    .READY_O(ready), .DATA_OUT_O(dout), .DATA_VALID_N_O(dv_n), .DISP_CHAR_O(ch), .ENTRY_MODE_O(mode),
    .DISPLAY_LEN_O(len), .CURSOR_ADDR_O(caddr), .CURSOR_SHOWN_O(shown), .INSERT_ACTIVE_O(ins));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] ca(int l, int p);
    return 16'(48 - l + p);
  endfunction : ca
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic peek(input int p, input logic [6:0] exp);
    pos = 6'(p);
    repeat (2) @(negedge clk);
    chk(16'(ch), 16'(exp));
  endtask : peek
  task automatic next_word(output logic [7:0] w);
    for (int n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (dv_n === 1'b0)
        break;
    end
    w = dout;
    while (dv_n === 1'b0)
      @(negedge clk);
  endtask : next_word
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (95000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    logic [7:0] w;
    seed = 32'h5eebf56e;
    {rstn, gap, pos, rfont} = '0;
    mrst_n = 1'b1;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(mode), 16'(MODE_LEFT));
    chk(16'(len), 16'(RESET_LEN));
    chk(16'(caddr), ca(32, 0));
    chk(16'(shown), 16'h1);
    for (i = 0; i < 4; i++)
    begin
      c[i] = 7'h20 + 7'($random(seed) & 32'h3f);
      u_host.send({1'b0, c[i]}, 5'h00);
      chk(16'(u_host.low_cyc), 16'(READY_LOW_CYC + 5));
      chk(16'(caddr), ca(32, i + 1));
      peek(i, c[i]);
    end
    u_host.send({1'b0, CMD_INSERT}, 5'h00);
    chk(16'(ins), 16'h1);
    u_host.send({1'b0, CMD_BACKSPACE}, 5'h00);
    chk(16'(ins), 16'h0);
    chk(16'(caddr), ca(32, 3));
    peek(3, c[3]);
    u_host.send({1'b0, CMD_BACKSPACE}, 5'h00);
    u_host.send({1'b0, CMD_DELETE}, 5'h00);
    peek(2, c[3]);
    u_host.send({1'b0, CMD_INSERT}, 5'h00);
    u_host.send({1'b0, c[2]}, 5'h00);
    peek(3, c[3]);
    peek(2, c[2]);
    u_host.send({1'b0, CMD_CURSOR_RIGHT}, 5'h00);
    chk(16'(caddr), ca(32, 4));
    chk(16'(ins), 16'h0);
    u_host.send({1'b0, CMD_CLEAR}, 5'h00);
    chk(16'(caddr), ca(32, 0));
    peek(0, CH_SPACE);
    $display("left entry done");
    for (i = 0; i < 4; i++)
    begin
      code = 4'(($random(seed) & 32'h7fffffff) % (i == 0 ? 8 : 12));
      u_host.send({1'b1, 2'(i), 1'b1, code}, 5'h00);
      chk(16'(mode), 16'(i));
      chk(16'(len), 16'(4 * (code + 1)));
    end
    u_host.send(8'hac, 5'h00);
    chk(16'(mode), 16'(MODE_BLOCK));
    u_host.send(8'hc3, 5'h00);
    chk(16'(caddr), 16'(CURSOR_OFFSCREEN));
    u_host.send({1'b0, CMD_DELETE}, 5'h00);
    peek(15, CMD_DELETE);
    u_host.send({1'b0, CMD_BACKSPACE}, 5'h00);
    peek(15, CH_SPACE);
    chk(16'(shown), 16'h0);
    u_host.send(8'h87, 5'h00);
    u_host.send(8'h41, 5'h05);
    peek(5, 7'h41);
    chk(16'(caddr), ca(32, 6));
    u_host.send(8'ha0, 5'h00);
    for (i = 0; i < 2; i++)
      u_host.send(8'h5a, 5'h00);
    chk(16'(caddr), ca(4, 4));
    $display("modes done");
    u_host.send(8'ha3, 5'h00);
    rfont = 1'b1;
    u_host.send({1'b0, 7'h61}, 5'h00);
    chk(16'(caddr), ca(16, 0));
    u_host.send({1'b0, c[0]}, 5'h00);
    rfont = 1'b0;
    gap = 1'b1;
    @(negedge clk);
    gap = 1'b0;
    for (i = 0; i < DUMP_WORDS; i++)
    begin
      next_word(w);
      chk(16'(w), i == 0 ? 16'ha3 : i == 1 ? ca(16, 1) : i == 2 ? 16'(c[0]) : 16'(CH_SPACE));
    end
    $display("dump done");
    u_host.strap(8'he5);
    mrst_n = 1'b0;
    repeat (24) @(negedge clk);
    mrst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(mode), 16'(MODE_BLOCK));
    chk(16'(len), 16'd24);
    chk(16'(shown), 16'h0);
    u_host.send({1'b0, c[1]}, 5'h00);
    chk(16'(caddr), ca(24, 1));
    peek(0, c[1]);
    $display("master reset done");
    u_host.strap(8'hd1);
    rstn = 1'b0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(mode), 16'(MODE_RIGHT));
    chk(16'(len), 16'h8);
    $display("reset strap done");
    wrap_up();
  end
endmodule : ascii_display_entry_controller_tb
